// File: smr_cfg.svh
// Constants for the mode-word configuration block: field positions, codes, latencies.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SMR_CFG_SVH
`define SMR_CFG_SVH

// Register byte offsets on the AXI4-Lite slave
`define SMR_OFS_MODE0 12'h000
`define SMR_OFS_MODE1 12'h004
`define SMR_OFS_CTRL 12'h008
`define SMR_OFS_STATUS 12'h00C
`define SMR_OFS_LAT 12'h010

// Mode word zero read latency field
`define SMR_CL_LSB 4
`define SMR_CL_MIN 4'h5
`define SMR_CL_MAX 4'hE
`define SMR_CL_DLL_OFF 4'h6

// Mode word one bit positions
`define SMR_B_DLL_DIS 0
`define SMR_B_DRV0 1
`define SMR_B_RTT0 2
`define SMR_B_AL0 3
`define SMR_B_AL1 4
`define SMR_B_DRV1 5
`define SMR_B_RTT1 6
`define SMR_B_WLVL 7
`define SMR_B_RTT2 9
`define SMR_B_TSTRB 11
`define SMR_B_QOFF 12
`define SMR_MR1_RSVD_MASK 19'h4E500

// Reset values of the mode words
`define SMR_MR0_RST 19'h00010
`define SMR_MR1_RST 19'h00000

// Control register bits
`define SMR_C_SREF_ENTER 0
`define SMR_C_SREF_EXIT 1
`define SMR_C_READ 2
`define SMR_C_WRITE 3
`define SMR_C_TCTL 4
`define SMR_C_CWL_LSB 8

// Default write column latency
`define SMR_CWL_RST 4'h5

// Delay pipeline depth for the read and write latency counters
`define SMR_PIPE_W 32

// AXI responses
`define SMR_RESP_OK 2'h0
`define SMR_RESP_DECERR 2'h3

`endif

// File: smr_pkg.sv
// Types shared by the mode-word configuration block.
// Assumes smr_cfg.svh is on the include path.
`include "smr_cfg.svh"
package smr_pkg;
    typedef enum logic [1:0] {
        SMR_RTT_OFF,
        SMR_NOMINAL_TERMINATION,
        SMR_WRITE_TERMINATION
    } smr_rtt_sel_t;

    typedef enum logic [1:0] {
        SMR_DLL_ON,
        SMR_DLL_OFF_SREF,
        SMR_DLL_OFF_USER
    } smr_dll_state_t;
endpackage

// File: smr_mode_cfg.sv
// Mode-word configuration logic: mode words zero and one, delay-locked loop
// state, termination selection and read/write latency pipelines.
// Assumes an AXI4-Lite master on ref_clk_in and a synchronous active-high reset.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "smr_cfg.svh"

// What this block does
// - Read column latency from three-bit field, settings 5 to 11 only.
// - Read registered at edge n yields first data at edge n plus m.
// - Mode word one loads by mode-set, held until rewritten or reset.
// - Write leveling with outputs off allows all nominal values, else write only.
// - Bit 0 enables or disables the loop; controller keeps it enabled.
// - Loop enabled at self refresh entry is turned off, then back on at exit.
// - Loop disabled at entry stays off after exit until re-enabled.
// - Loop off forbids termination, unaligned data, latencies fixed at six.
// - Bits 5 and 1 choose drive impedance; controller picks over-seven setting.
// - Bit 12 at one tri-states all data and strobe outputs.
// - Bit 11 extends strobe termination to termination strobe, removing byte mask.
// - Bits 9, 6, 2 choose nominal termination over 2, 4, 6, 8, 12.
// - Writes with write termination enabled substitute the write value.
// - Termination control pin gates nominal termination when it is enabled.
// - Bit 7 enables write leveling mode.
// - Bits 4 and 3 choose additive latency zero, latency minus one or two.
// - Total write latency is write column latency plus additive latency.
module smr_mode_cfg
    import smr_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic termination_control_in,
    output logic dll_enabled_out,
    output logic dll_reset_out,
    output logic [1:0] drive_strength_out,
    output logic outputs_tristate_out,
    output logic termination_strobe_out,
    output logic write_byte_mask_en_out,
    output logic write_leveling_out,
    output logic [2:0] nominal_termination_out,
    output logic [1:0] termination_sel_out,
    output logic read_data_start_out,
    output logic write_data_start_out
);

    // Whole block state
    typedef struct packed {
        logic [18:0] mode_zero;
        logic [18:0] mode_one;
        logic [3:0] write_column_latency;
        logic tctl_s1;
        logic tctl_s2;
        logic tctl_s3;
        logic tctl;
        smr_dll_state_t dll;
        logic dll_rst;
        logic in_sref;
        logic [`SMR_PIPE_W-1:0] rd_pipe;
        logic [`SMR_PIPE_W-1:0] wr_pipe;
        logic [4:0] wr_busy;
        logic aw_got;
        logic w_got;
        logic [11:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rd_pulse;
        logic wr_pulse;
    } smr_state_t;

    smr_state_t cur_ff;
    smr_state_t nxt_s;

    // Effective read column latency, clamped to the legal range
    function automatic logic [3:0] eff_cl(input logic [18:0] m0, input logic dll_on);
        logic [3:0] raw;
        // Field value plus four is the latency
        raw = {1'b0, m0[`SMR_CL_LSB +: 3]} + 4'h4;
        if (!dll_on) begin
            eff_cl = `SMR_CL_DLL_OFF;
        end else if (raw < `SMR_CL_MIN) begin
            eff_cl = `SMR_CL_MIN;
        end else if (raw > `SMR_CL_MAX) begin
            eff_cl = `SMR_CL_MAX;
        end else begin
            eff_cl = raw;
        end
    endfunction

    // Posted additive latency decode
    function automatic logic [3:0] add_lat(input logic [18:0] m1, input logic [3:0] cl);
        unique case ({m1[`SMR_B_AL1], m1[`SMR_B_AL0]})
            2'h1: add_lat = cl - 4'h1;
            2'h2: add_lat = cl - 4'h2;
            default: add_lat = 4'h0;
        endcase
    endfunction

    // Merge write data into a 19-bit word under byte strobes
    function automatic logic [18:0] merge19(input logic [18:0] old, input logic [31:0] d,
                                            input logic [3:0] st);
        logic [31:0] w;
        w = {13'h0000, old};
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                w[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        merge19 = w[18:0];
    endfunction

    // Values derived from the mode words
    logic dll_on;
    logic [3:0] cl_now;
    logic [3:0] al_now;
    logic [4:0] rl_now;
    logic [4:0] wl_now;
    logic [3:0] cwl_now;
    logic nominal_termination_en;
    logic write_termination_allowed;

    // Derived latencies and termination permissions
    always_comb begin
        dll_on = (cur_ff.dll == SMR_DLL_ON);
        cl_now = eff_cl(cur_ff.mode_zero, dll_on);
        al_now = add_lat(cur_ff.mode_one, cl_now);
        cwl_now = dll_on ? cur_ff.write_column_latency : `SMR_CL_DLL_OFF;
        rl_now = {1'b0, al_now} + {1'b0, cl_now};
        wl_now = {1'b0, al_now} + {1'b0, cwl_now};
        nominal_termination_en = ({cur_ff.mode_one[`SMR_B_RTT2], cur_ff.mode_one[`SMR_B_RTT1],
                       cur_ff.mode_one[`SMR_B_RTT0]} != 3'h0) && dll_on;
        // Leveling with outputs on keeps only write values usable
        write_termination_allowed = !cur_ff.mode_one[`SMR_B_WLVL] || cur_ff.mode_one[`SMR_B_QOFF];
    end

    // Scratch words of the next-state process
    logic [18:0] new_one;
    logic [31:0] ctl_word;

    // Next-state logic: bus slave, mode words, loop state and latency pipes
    always_comb begin
        nxt_s = cur_ff;
        new_one = cur_ff.mode_one;
        ctl_word = 32'h0000_0000;
        nxt_s.rd_pulse = 1'b0;
        nxt_s.wr_pulse = 1'b0;
        nxt_s.dll_rst = 1'b0;
        // Three-stage pin synchroniser, change accepted when stages 2 and 3 agree
        nxt_s.tctl_s1 = termination_control_in;
        nxt_s.tctl_s2 = cur_ff.tctl_s1;
        nxt_s.tctl_s3 = cur_ff.tctl_s2;
        if (cur_ff.tctl_s2 == cur_ff.tctl_s3) begin
            nxt_s.tctl = cur_ff.tctl_s3;
        end
        // Latency pipes shift each cycle; bit k fires k+1 edges after the command
        nxt_s.rd_pipe = {1'b0, cur_ff.rd_pipe[`SMR_PIPE_W-1:1]};
        nxt_s.wr_pipe = {1'b0, cur_ff.wr_pipe[`SMR_PIPE_W-1:1]};
        nxt_s.rd_pulse = cur_ff.rd_pipe[0];
        nxt_s.wr_pulse = cur_ff.wr_pipe[0];
        // Write termination window counts down
        if (cur_ff.wr_busy != 5'h00) begin
            nxt_s.wr_busy = cur_ff.wr_busy - 5'h01;
        end
        // Write address and data channels, taken in either order
        if (s_axi_awvalid_in && !cur_ff.aw_got) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !cur_ff.w_got) begin
            nxt_s.w_got = 1'b1;
            nxt_s.w_data = s_axi_wdata_in;
            nxt_s.w_strb = s_axi_wstrb_in;
        end
        // Both halves held: apply the word and raise the answer on the same edge
        if (cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = `SMR_RESP_OK;
            unique case (cur_ff.aw_addr)
                `SMR_OFS_MODE0: begin
                    nxt_s.mode_zero = merge19(cur_ff.mode_zero, cur_ff.w_data,
                                              cur_ff.w_strb);
                end
                `SMR_OFS_MODE1: begin
                    new_one = merge19(cur_ff.mode_one, cur_ff.w_data, cur_ff.w_strb);
                    nxt_s.mode_one = new_one;
                    // Loop enable bit is active low in the mode word
                    if (!new_one[`SMR_B_DLL_DIS]) begin
                        if (cur_ff.dll != SMR_DLL_ON && !cur_ff.in_sref) begin
                            nxt_s.dll = SMR_DLL_ON;
                        end
                    end else if (!cur_ff.in_sref) begin
                        nxt_s.dll = SMR_DLL_OFF_USER;
                    end
                end
                `SMR_OFS_CTRL: begin
                    ctl_word = cur_ff.w_data;
                    // New write latency serves later commands only
                    if (cur_ff.w_strb[1]) begin
                        nxt_s.write_column_latency = ctl_word[`SMR_C_CWL_LSB +: 4];
                    end
                    if (cur_ff.w_strb[0]) begin
                        // Self refresh entry and exit steer the loop
                        if (ctl_word[`SMR_C_SREF_ENTER] && !cur_ff.in_sref) begin
                            nxt_s.in_sref = 1'b1;
                            if (cur_ff.dll == SMR_DLL_ON) begin
                                nxt_s.dll = SMR_DLL_OFF_SREF;
                            end
                        end else if (ctl_word[`SMR_C_SREF_EXIT] && cur_ff.in_sref) begin
                            nxt_s.in_sref = 1'b0;
                            if (cur_ff.dll == SMR_DLL_OFF_SREF) begin
                                nxt_s.dll = SMR_DLL_ON;
                                nxt_s.dll_rst = 1'b1;
                            end
                            // Loop turned off by software stays off
                        end
                        // Commands arm a latency pipe, never in self refresh
                        if (ctl_word[`SMR_C_READ] && !cur_ff.in_sref) begin
                            nxt_s.rd_pipe[rl_now - 5'h02] = 1'b1;
                            nxt_s.wr_busy = 5'h00;
                        end
                        if (ctl_word[`SMR_C_WRITE] && !cur_ff.in_sref) begin
                            nxt_s.wr_pipe[wl_now - 5'h02] = 1'b1;
                            nxt_s.wr_busy = wl_now + 5'h04;
                        end
                    end
                end
                default: begin
                    // Unmapped offset: refused, nothing changes
                    nxt_s.bresp = `SMR_RESP_DECERR;
                end
            endcase
        end
        // Response leaves once taken
        if (cur_ff.bvalid && s_axi_bready_in) begin
            nxt_s.bvalid = 1'b0;
        end
        // Read channel
        if (s_axi_arvalid_in && !cur_ff.rvalid) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = `SMR_RESP_OK;
            unique case (s_axi_araddr_in)
                `SMR_OFS_MODE0: nxt_s.rdata = {13'h0000, cur_ff.mode_zero};
                `SMR_OFS_MODE1: nxt_s.rdata = {13'h0000, cur_ff.mode_one};
                `SMR_OFS_CTRL: nxt_s.rdata = {20'h00000, cur_ff.write_column_latency, 8'h00};
                `SMR_OFS_STATUS: nxt_s.rdata = {28'h0000000, cur_ff.tctl, cur_ff.in_sref,
                                                cur_ff.dll};
                `SMR_OFS_LAT: nxt_s.rdata = {11'h000, wl_now, 3'h0, rl_now, al_now,
                                             cl_now};
                default: begin
                    // Unmapped offset reads as zero
                    nxt_s.rdata = 32'h0000_0000;
                    nxt_s.rresp = `SMR_RESP_DECERR;
                end
            endcase
        end else if (cur_ff.rvalid && s_axi_rready_in) begin
            nxt_s.rvalid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            nxt_s_reset();
        end else begin
            cur_ff <= nxt_s;
        end
    end

    // Reset image of the state, held by a task so each field has a constant
    task automatic nxt_s_reset();
        cur_ff <= '0;
        cur_ff.mode_zero <= `SMR_MR0_RST;
        cur_ff.mode_one <= `SMR_MR1_RST;
        cur_ff.write_column_latency <= `SMR_CWL_RST;
        cur_ff.dll <= SMR_DLL_ON;
    endtask

    // Bus handshakes
    assign s_axi_awready_out = !cur_ff.aw_got;
    assign s_axi_wready_out = !cur_ff.w_got;
    assign s_axi_bvalid_out = cur_ff.bvalid;
    assign s_axi_bresp_out = cur_ff.bresp;
    assign s_axi_arready_out = !cur_ff.rvalid;
    assign s_axi_rvalid_out = cur_ff.rvalid;
    assign s_axi_rdata_out = cur_ff.rdata;
    assign s_axi_rresp_out = cur_ff.rresp;

    // Mode-word driven controls
    assign dll_enabled_out = (cur_ff.dll == SMR_DLL_ON);
    assign dll_reset_out = cur_ff.dll_rst;
    assign drive_strength_out = {cur_ff.mode_one[`SMR_B_DRV1],
                                 cur_ff.mode_one[`SMR_B_DRV0]};
    assign outputs_tristate_out = cur_ff.mode_one[`SMR_B_QOFF];
    assign termination_strobe_out = cur_ff.mode_one[`SMR_B_TSTRB];
    assign write_byte_mask_en_out = !cur_ff.mode_one[`SMR_B_TSTRB];
    assign write_leveling_out = cur_ff.mode_one[`SMR_B_WLVL];
    assign nominal_termination_out = {cur_ff.mode_one[`SMR_B_RTT2],
                                      cur_ff.mode_one[`SMR_B_RTT1],
                                      cur_ff.mode_one[`SMR_B_RTT0]};
    assign read_data_start_out = cur_ff.rd_pulse;
    assign write_data_start_out = cur_ff.wr_pulse;

    // Termination selection: pin gates nominal, writes substitute write value
    always_comb begin
        if (!nominal_termination_en || !cur_ff.tctl || cur_ff.in_sref) begin
            termination_sel_out = SMR_RTT_OFF;
        end else if (cur_ff.wr_busy != 5'h00 && dll_on) begin
            termination_sel_out = SMR_WRITE_TERMINATION;
        end else if (!write_termination_allowed) begin
            termination_sel_out = SMR_WRITE_TERMINATION;
        end else begin
            termination_sel_out = SMR_NOMINAL_TERMINATION;
        end
    end

endmodule

// File: smr_mode_cfg_assertions.sv
// Port-level checks for the mode-word configuration block.
// Assumes a bind onto smr_mode_cfg; one clock, synchronous active-high reset.
`timescale 1ns/1ps
`include "smr_cfg.svh"
module smr_mode_cfg_assertions (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic dll_enabled_out,
    input wire logic dll_reset_out,
    input wire logic outputs_tristate_out,
    input wire logic termination_strobe_out,
    input wire logic write_byte_mask_en_out,
    input wire logic [1:0] termination_sel_out,
    input wire logic read_data_start_out,
    input wire logic write_data_start_out
);
    logic qoff_load;
    logic qoff_exp_ff;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // A mode word one write taken in one cycle, output disable byte enabled
    assign qoff_load = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out && s_axi_awaddr_in == `SMR_OFS_MODE1 && s_axi_wstrb_in[1];
    // Remembers the output disable bit of the last such write
    always_ff @(posedge ref_clk_in) begin
        if (qoff_load) begin
            qoff_exp_ff <= s_axi_wdata_in[`SMR_B_QOFF];
        end
    end
    a_qoff_load: assert property (qoff_load |-> ##3 outputs_tristate_out == qoff_exp_ff)
        else $error("output disable does not follow mode word one");
    a_mask_strobe: assert property (write_byte_mask_en_out == !termination_strobe_out)
        else $error("byte mask and termination strobe both on or both off");
    a_dll_noterm: assert property (!dll_enabled_out |-> termination_sel_out == 2'h0)
        else $error("termination selected with loop off");
    a_dll_reset_on: assert property (dll_reset_out |-> ##[0:1] dll_enabled_out)
        else $error("loop reset without loop enabled");
    a_dll_reset_pulse: assert property (dll_reset_out |=> !dll_reset_out)
        else $error("loop reset longer than one cycle");
    a_read_pulse: assert property ($rose(read_data_start_out) |=> !read_data_start_out)
        else $error("read start longer than one cycle");
    a_write_pulse: assert property (write_data_start_out |=> !write_data_start_out)
        else $error("write start longer than one cycle");
    a_bvalid_hold: assert property (s_axi_bvalid_out |=> s_axi_bvalid_out || $past(s_axi_bready_in))
        else $error("write response dropped before taken");
    a_rdata_hold: assert property (s_axi_rvalid_out |=> $past(s_axi_rready_in)
        || (s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out)))
        else $error("read answer changed before taken");
endmodule
bind smr_mode_cfg smr_mode_cfg_assertions smr_mode_cfg_assertions_i (.*);

// File: smr_ctrl_model.sv
// Memory-controller model: AXI4-Lite master issuing mode-set and control writes.
// Assumes the bench calls one task at a time, only while the device is idle.
`timescale 1ns/1ps
`include "smr_cfg.svh"
module smr_ctrl_model (
    input wire logic ref_clk_in,
    output logic [11:0] awaddr_out,
    output logic awvalid_out,
    input wire logic awready_in,
    output logic [31:0] wdata_out,
    output logic [3:0] wstrb_out,
    output logic wvalid_out,
    input wire logic wready_in,
    input wire logic [1:0] bresp_in,
    input wire logic bvalid_in,
    output logic bready_out,
    output logic [11:0] araddr_out,
    output logic arvalid_out,
    input wire logic arready_in,
    input wire logic [31:0] rdata_in,
    input wire logic [1:0] rresp_in,
    input wire logic rvalid_in,
    output logic rready_out
);
    // Idle bus at time zero
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
        {araddr_out, arvalid_out, rready_out} = '0;
    end
    // One write at a time; reserved bits of mode word one forced to zero
    task automatic write_word(input logic [11:0] a, input logic [31:0] d,
        output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge ref_clk_in);
        awaddr_out <= a;
        wdata_out <= (a == `SMR_OFS_MODE1) ? (d & ~{13'h0, `SMR_MR1_RSVD_MASK}) : d;
        {awvalid_out, wvalid_out, bready_out, wstrb_out} <= {3'h7, 4'hF};
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk_in);
            if (!aw_done && awready_in) begin
                aw_done = 1'b1;
                awvalid_out <= 1'b0;
                awaddr_out <= ~a;
            end
            if (!w_done && wready_in) begin
                w_done = 1'b1;
                wvalid_out <= 1'b0;
                wdata_out <= ~d;
            end
        end
        while (!bvalid_in) @(posedge ref_clk_in);
        resp = bresp_in;
        bready_out <= 1'b0;
    endtask
    // One read at a time
    task automatic read_word(input logic [11:0] a, output logic [31:0] d,
        output logic [1:0] resp);
        @(posedge ref_clk_in);
        {araddr_out, arvalid_out, rready_out} <= {a, 2'h3};
        do @(posedge ref_clk_in); while (!arready_in);
        {araddr_out, arvalid_out} <= {~a, 1'b0};
        while (!rvalid_in) @(posedge ref_clk_in);
        {d, resp} = {rdata_in, rresp_in};
        rready_out <= 1'b0;
    endtask
endmodule

// File: smr_mode_cfg_tb.sv
// Self-checking bench for the mode-word configuration block.
// Assumes the controller model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "smr_cfg.svh"
module smr_mode_cfg_tb;
    logic ref_clk_in, rst_in, termination_control_in;
    logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd;
    logic [3:0] s_axi_wstrb_in;
    logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
    logic s_axi_rvalid_out, s_axi_rready_in, dll_enabled_out, dll_reset_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, drive_strength_out, termination_sel_out, rsp;
    logic outputs_tristate_out, termination_strobe_out, write_byte_mask_en_out;
    logic write_leveling_out, read_data_start_out, write_data_start_out;
    logic [2:0] nominal_termination_out;
    logic [31:0] pats [2] = '{32'h00C4, 32'h1A22};
    int bad_count = 0, samples_checked = 0, dll_resets = 0, write_column_latency = 5;
    int r0, r1, r2, w0, w1, w2;
    smr_mode_cfg smr_mode_cfg_i (.*);
    smr_ctrl_model smr_ctrl_model_i (.ref_clk_in, .awaddr_out(s_axi_awaddr_in),
        .awvalid_out(s_axi_awvalid_in), .awready_in(s_axi_awready_out),
        .wdata_out(s_axi_wdata_in), .wstrb_out(s_axi_wstrb_in), .wvalid_out(s_axi_wvalid_in),
        .wready_in(s_axi_wready_out), .bresp_in(s_axi_bresp_out), .bvalid_in(s_axi_bvalid_out),
        .bready_out(s_axi_bready_in), .araddr_out(s_axi_araddr_in),
        .arvalid_out(s_axi_arvalid_in), .arready_in(s_axi_arready_out),
        .rdata_in(s_axi_rdata_out), .rresp_in(s_axi_rresp_out), .rvalid_in(s_axi_rvalid_out),
        .rready_out(s_axi_rready_in));
    // Clock and loop reset pulse counter
    always #12.5 ref_clk_in = ~ref_clk_in;
    always @(negedge ref_clk_in) if (dll_reset_out === 1'b1) dll_resets++;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        smr_ctrl_model_i.write_word(a, d, rsp);
        check(rsp, `SMR_RESP_OK);
    endtask
    task automatic rdw(input logic [11:0] a);
        smr_ctrl_model_i.read_word(a, rd, rsp);
    endtask
    task automatic settle;
        repeat (6) @(negedge ref_clk_in);
    endtask
    // Cycles from the return of the command write until its first read or write data pulse
    task automatic meas(input int bit_n, output int n);
        wr(`SMR_OFS_CTRL, (1 << bit_n) | (write_column_latency << `SMR_C_CWL_LSB));
        n = 0;
        while (n < 100 && !(bit_n == 2 ? read_data_start_out : write_data_start_out)) begin
            @(negedge ref_clk_in);
            n++;
        end
    endtask
    task automatic t_reset;
        rdw(`SMR_OFS_MODE0);
        check(rd, 32'h10);
        rdw(`SMR_OFS_LAT);
        check(rd, 32'h00050505);
        smr_ctrl_model_i.write_word(12'h020, 32'hF, rsp);
        check(rsp, `SMR_RESP_DECERR);
        rdw(12'h020);
        check(rd, 32'h0);
        check(rsp, `SMR_RESP_DECERR);
    endtask
    task automatic t_cl_al;
        for (int f = 0; f < 8; f++) begin
            wr(`SMR_OFS_MODE0, f << `SMR_CL_LSB);
            rdw(`SMR_OFS_LAT);
            check(rd, 32'h00050000 | ((f < 1 ? 5 : f + 4) * 32'h101));
        end
        wr(`SMR_OFS_MODE0, 32'h40);
        for (int c = 0; c < 4; c++) begin
            wr(`SMR_OFS_MODE1, c << `SMR_B_AL0);
            rdw(`SMR_OFS_LAT);
            w0 = (c == 1) ? 7 : (c == 2) ? 6 : 0;
            check(rd, ((5 + w0) << 16) | ((8 + w0) << 8) | (w0 << 4) | 8);
        end
    endtask
    task automatic t_latency;
        wr(`SMR_OFS_MODE1, 32'h0);
        meas(2, r0);
        meas(3, w0);
        wr(`SMR_OFS_MODE1, 32'h8);
        meas(2, r1);
        meas(3, w1);
        check(r1 - r0, 7);
        check(w1 - w0, 7);
        wr(`SMR_OFS_MODE1, 32'h0);
        wr(`SMR_OFS_MODE0, 32'h10);
        meas(2, r2);
        check(r0 - r2, 3);
        write_column_latency = 8;
        wr(`SMR_OFS_CTRL, write_column_latency << `SMR_C_CWL_LSB);
        meas(3, w2);
        check(w2 - w0, 3);
        check(r2 < 100, 1);
    endtask
    task automatic t_dll;
        wr(`SMR_OFS_MODE1, 32'h4);
        @(posedge ref_clk_in) termination_control_in <= 1'b1;
        settle;
        check(termination_sel_out, 2'h1);
        for (int pass = 0; pass < 2; pass++) begin
            r0 = dll_resets;
            wr(`SMR_OFS_CTRL, 1 | (write_column_latency << `SMR_C_CWL_LSB));
            settle;
            check(dll_enabled_out, 1'b0);
            rdw(`SMR_OFS_STATUS);
            check(rd[2:0], pass ? 3'h6 : 3'h5);
            wr(`SMR_OFS_CTRL, 2 | (write_column_latency << `SMR_C_CWL_LSB));
            settle;
            check(dll_enabled_out, pass ? 1'b0 : 1'b1);
            check(dll_resets - r0, 1 - pass);
            if (pass == 0) begin
                wr(`SMR_OFS_MODE1, 32'h5);
                settle;
                check({dll_enabled_out, termination_sel_out}, 3'h0);
                rdw(`SMR_OFS_LAT);
                check(rd, 32'h00060606);
            end
        end
        wr(`SMR_OFS_MODE1, 32'h4);
        settle;
        check({dll_enabled_out, termination_sel_out}, 3'h5);
        wr(`SMR_OFS_MODE0, 32'h110);
        @(posedge ref_clk_in) termination_control_in <= 1'b0;
        settle;
        check(termination_sel_out, 2'h0);
    endtask
    task automatic t_fields;
        foreach (pats[i]) begin
            wr(`SMR_OFS_MODE1, pats[i]);
            settle;
            check(drive_strength_out, {pats[i][5], pats[i][1]});
            check(nominal_termination_out, {pats[i][9], pats[i][6], pats[i][2]});
            check({outputs_tristate_out, write_leveling_out}, {pats[i][12], pats[i][7]});
            check({termination_strobe_out, write_byte_mask_en_out}, {pats[i][11], !pats[i][11]});
            rdw(`SMR_OFS_MODE1);
            check(rd, pats[i]);
        end
        @(posedge ref_clk_in) rst_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rdw(`SMR_OFS_MODE1);
        check(rd, 32'h0);
        check({outputs_tristate_out, termination_strobe_out}, 2'h0);
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        bad_count++;
        finish_test;
    end
    // Main sequence
    initial begin
        ref_clk_in = 1'b0;
        rst_in = 1'b1;
        termination_control_in = 1'b0;
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_reset;
        t_cl_al;
        t_latency;
        t_dll;
        t_fields;
        finish_test;
    end
endmodule
